// *** rtl/vc_cap_pkg.sv ***
package vc_cap_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [11:0] port_vc_capability_first_off  = 12'h204;
  localparam logic [11:0] port_vc_capability_second_off = 12'h208;

  // ==========================================================================
  // First register field positions
  localparam int ext_vc_count_lsb         = 0;
  localparam int ext_vc_count_w           = 3;
  localparam int lp_ext_vc_count_lsb      = 4;
  localparam int lp_ext_vc_count_w        = 3;
  localparam int timebase_lsb             = 8;
  localparam int timebase_w               = 2;
  localparam int entry_size_lsb           = 10;
  localparam int entry_size_w             = 2;

  // ==========================================================================
  // Second register field positions
  localparam int arb_schemes_lsb          = 0;
  localparam int arb_schemes_w            = 8;
  localparam int arb_schemes_defined_w    = 4;
  localparam int arb_table_offset_lsb     = 24;
  localparam int arb_table_offset_w       = 8;
  localparam int arb_table_offset_unit_b  = 16;

  // ==========================================================================
  // Field values
  localparam logic [2:0] ext_vc_count_val    = 3'h0;
  localparam logic [2:0] lp_ext_vc_count_val = 3'h0;
  localparam logic [1:0] timebase_val        = 2'h0;
  localparam logic [7:0] arb_schemes_val     = 8'h00;
  localparam logic [7:0] arb_table_off_val   = 8'h00;
  localparam logic [31:0] second_reset_val   = 32'h0000_0000;

  // Entry size encodings
  localparam logic [1:0] entry_1bit = 2'h0;
  localparam logic [1:0] entry_2bit = 2'h1;
  localparam logic [1:0] entry_4bit = 2'h2;
  localparam logic [1:0] entry_8bit = 2'h3;

  // Scheme bit positions in the arbitration schemes field
  localparam int scheme_fixed_rr  = 0;
  localparam int scheme_wrr_32    = 1;
  localparam int scheme_wrr_64    = 2;
  localparam int scheme_wrr_128   = 3;

endpackage

// *** rtl/vc_port_capability_regs.sv ***
`timescale 1ns/1ps
// Contract
// - Extended VC count, bits 2:0, always reads zero.
// - Low priority extended VC count, bits 6:4, always reads zero.
// - Arbitration timebase select, bits 9:8, always reads zero.
// - Entry size bits 11:10 read 0x2 upstream, 0x0 downstream.
// - Entry size codes: 0=1-bit, 1=2-bit, 2=4-bit, 3=8-bit.
// - VC arbitration schemes, bits 7:0, read zero.
// - Scheme bits 4 to 7 reserved, never set.
// - VC arbitration table offset, bits 31:24, 16-byte units, reads zero.

module vc_port_capability_regs #(
  parameter int addr_w = 12
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Port role strap, same clock domain
  input  wire logic              upstream_port,
  // Register port
  input  wire logic [addr_w-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata
);

  // ==========================================================================
  // Local sizes
  localparam int         reg_w          = 32;
  localparam int         offset_w       = 12;
  localparam int         scheme_bits    = vc_cap_pkg::arb_schemes_w;
  localparam int         scheme_defined = vc_cap_pkg::arb_schemes_defined_w;
  localparam logic [1:0] sel_first      = 2'b01;
  localparam logic [1:0] sel_second     = 2'b10;

  // ==========================================================================
  // First register fields
  logic [2:0]       extended_vc_count;
  logic [2:0]       low_prio_extended_vc_count;
  logic [1:0]       arbitration_timebase_select;
  logic [1:0]       port_arb_table_entry_size;

  // ==========================================================================
  // Second register fields
  logic [7:0]       vc_arbitration_schemes;
  logic [7:0]       vc_arb_table_offset;

  // ==========================================================================
  // Scheme support flags
  logic             sup_fixed_rr;
  logic             sup_wrr_32;
  logic             sup_wrr_64;
  logic             sup_wrr_128;
  logic [3:0]       scheme_flags;

  // ==========================================================================
  // Register images and masks
  logic [reg_w-1:0] first_raw;
  logic [reg_w-1:0] second_raw;
  logic [reg_w-1:0] first_defined_mask;
  logic [reg_w-1:0] second_defined_mask;
  logic [reg_w-1:0] first_val;
  logic [reg_w-1:0] second_val;

  // ==========================================================================
  // Read path
  logic             hit_first;
  logic             hit_second;
  logic             rd_first;
  logic             rd_second;
  logic [1:0]       rd_sel;
  logic [reg_w-1:0] rdata_d;
  logic [reg_w-1:0] rdata_q;

  // ==========================================================================
  // Mask of the bits a field occupies
  function automatic logic [31:0] field_mask(
    input int lsb,
    input int width
  );
    logic [31:0] mask;

    mask = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if ((i >= lsb) && (i < (lsb + width))) begin
        mask[i] = 1'b1;
      end
    end
    return mask;
  endfunction

  // ==========================================================================
  // Copy a value into a field of a word
  function automatic logic [31:0] place_field(
    input logic [31:0] base,
    input int          lsb,
    input int          width,
    input logic [31:0] value
  );
    logic [31:0] result;

    result = base;
    for (int i = 0; i < width; i++) begin
      result[lsb + i] = value[i];
    end
    return result;
  endfunction

  // ==========================================================================
  // Register address match at any address width up to 32 bits
  function automatic logic addr_hit(
    input logic [addr_w-1:0]   addr,
    input logic [offset_w-1:0] offset
  );
    logic [31:0] wide_addr;
    logic [31:0] wide_off;

    wide_addr = 32'h0000_0000;
    wide_addr[addr_w-1:0] = addr;
    wide_off = 32'h0000_0000;
    wide_off[offset_w-1:0] = offset;
    return wide_addr == wide_off;
  endfunction

  // ==========================================================================
  // Entry size code for the port role
  function automatic logic [1:0] entry_code(
    input logic up
  );
    logic [1:0] code;

    unique case (up)
      1'b1: begin
        code = vc_cap_pkg::entry_4bit;
      end
      1'b0: begin
        code = vc_cap_pkg::entry_1bit;
      end
    endcase
    return code;
  endfunction

  // ==========================================================================
  // Extended VC count
  always_comb begin
    extended_vc_count = vc_cap_pkg::ext_vc_count_val;
  end

  // ==========================================================================
  // Low priority extended VC count
  always_comb begin
    low_prio_extended_vc_count = vc_cap_pkg::lp_ext_vc_count_val;
  end

  // ==========================================================================
  // Arbitration timebase select
  always_comb begin
    arbitration_timebase_select = vc_cap_pkg::timebase_val;
  end

  // ==========================================================================
  // Entry size follows the port role at read time
  always_comb begin
    port_arb_table_entry_size = entry_code(upstream_port);
  end

  // ==========================================================================
  // Scheme flags; no scheme is offered with one VC
  assign sup_fixed_rr = vc_cap_pkg::arb_schemes_val[vc_cap_pkg::scheme_fixed_rr];
  assign sup_wrr_32   = vc_cap_pkg::arb_schemes_val[vc_cap_pkg::scheme_wrr_32];
  assign sup_wrr_64   = vc_cap_pkg::arb_schemes_val[vc_cap_pkg::scheme_wrr_64];
  assign sup_wrr_128  = vc_cap_pkg::arb_schemes_val[vc_cap_pkg::scheme_wrr_128];

  always_comb begin
    scheme_flags = 4'h0;
    scheme_flags[vc_cap_pkg::scheme_fixed_rr] = sup_fixed_rr;
    scheme_flags[vc_cap_pkg::scheme_wrr_32]   = sup_wrr_32;
    scheme_flags[vc_cap_pkg::scheme_wrr_64]   = sup_wrr_64;
    scheme_flags[vc_cap_pkg::scheme_wrr_128]  = sup_wrr_128;
  end

  // ==========================================================================
  // Scheme field; bits above the defined ones are reserved
  generate
    for (genvar b = 0; b < scheme_bits; b++) begin : g_scheme
      if (b < scheme_defined) begin : g_defined
        assign vc_arbitration_schemes[b] = scheme_flags[b];
      end else begin : g_reserved
        assign vc_arbitration_schemes[b] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================================
  // Table offset; zero means no table
  always_comb begin
    vc_arb_table_offset = vc_cap_pkg::arb_table_off_val;
  end

  // ==========================================================================
  // First register image
  always_comb begin
    first_raw = 32'h0000_0000;
    first_raw = place_field(first_raw, vc_cap_pkg::ext_vc_count_lsb,
                            vc_cap_pkg::ext_vc_count_w, 32'(extended_vc_count));
    first_raw = place_field(first_raw, vc_cap_pkg::lp_ext_vc_count_lsb,
                            vc_cap_pkg::lp_ext_vc_count_w, 32'(low_prio_extended_vc_count));
    first_raw = place_field(first_raw, vc_cap_pkg::timebase_lsb,
                            vc_cap_pkg::timebase_w, 32'(arbitration_timebase_select));
    first_raw = place_field(first_raw, vc_cap_pkg::entry_size_lsb,
                            vc_cap_pkg::entry_size_w, 32'(port_arb_table_entry_size));
  end

  // ==========================================================================
  // Second register image
  always_comb begin
    second_raw = vc_cap_pkg::second_reset_val;
    second_raw = place_field(second_raw, vc_cap_pkg::arb_schemes_lsb,
                             vc_cap_pkg::arb_schemes_w, 32'(vc_arbitration_schemes));
    second_raw = place_field(second_raw, vc_cap_pkg::arb_table_offset_lsb,
                             vc_cap_pkg::arb_table_offset_w, 32'(vc_arb_table_offset));
  end

  // ==========================================================================
  // Bits that carry a defined field, first register
  always_comb begin
    first_defined_mask = 32'h0000_0000;
    first_defined_mask = first_defined_mask |
      field_mask(vc_cap_pkg::ext_vc_count_lsb, vc_cap_pkg::ext_vc_count_w);
    first_defined_mask = first_defined_mask |
      field_mask(vc_cap_pkg::lp_ext_vc_count_lsb, vc_cap_pkg::lp_ext_vc_count_w);
    first_defined_mask = first_defined_mask |
      field_mask(vc_cap_pkg::timebase_lsb, vc_cap_pkg::timebase_w);
    first_defined_mask = first_defined_mask |
      field_mask(vc_cap_pkg::entry_size_lsb, vc_cap_pkg::entry_size_w);
  end

  // ==========================================================================
  // Bits that carry a defined field, second register
  always_comb begin
    second_defined_mask = 32'h0000_0000;
    second_defined_mask = second_defined_mask |
      field_mask(vc_cap_pkg::arb_schemes_lsb, scheme_defined);
    second_defined_mask = second_defined_mask |
      field_mask(vc_cap_pkg::arb_table_offset_lsb, vc_cap_pkg::arb_table_offset_w);
  end

  // ==========================================================================
  // Reserved positions always read zero
  generate
    for (genvar k = 0; k < reg_w; k++) begin : g_bit
      assign first_val[k]  = first_raw[k] & first_defined_mask[k];
      assign second_val[k] = second_raw[k] & second_defined_mask[k];
    end
  endgenerate

  // ==========================================================================
  // Address decode
  assign hit_first  = addr_hit(reg_addr, vc_cap_pkg::port_vc_capability_first_off);
  assign hit_second = addr_hit(reg_addr, vc_cap_pkg::port_vc_capability_second_off);

  always_comb begin
    rd_first  = reg_rd && hit_first;
    rd_second = reg_rd && hit_second;
    rd_sel    = {rd_second, rd_first};
  end

  // ==========================================================================
  // Write strobe and data are taken and dropped
  // Every field is fixed, so a write has nothing to change

  // ==========================================================================
  // Read data mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (rd_sel)
      sel_first: begin
        rdata_d = first_val;
      end
      sel_second: begin
        rdata_d = second_val;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================================
  // Read data register; zero unless a read happened
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// *** test/vc_cap_asserts.sv ***
`timescale 1ns/1ps
module vc_cap_asserts (
  // Clock, reset, strap
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        upstream_port,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ==========================================
  // Read data checks
  idle_data_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("idle");
  ext_count_zero_a: assert property (reg_rd |=> reg_rdata[2:0] == 3'h0) else $error("ext");
  lp_count_zero_a: assert property (reg_rd |=> reg_rdata[6:4] == 3'h0) else $error("lp");
  timebase_zero_a: assert property (reg_rd |=> reg_rdata[9:8] == 2'h0) else $error("tb");
  entry_size_a: assert property (reg_rd && reg_addr == 12'h204 |=>
    reg_rdata[11:10] == ($past(upstream_port) ? 2'h2 : 2'h0)) else $error("size");
  arb_schemes_zero_a: assert property (reg_rd |=> reg_rdata[7:0] == 8'h0) else $error("arb");
  table_offset_zero_a: assert property (reg_rd |=> reg_rdata[31:24] == 8'h0) else $error("off");
  reserved_bits_a: assert property (reg_rd |=> reg_rdata[23:12] == 12'h0) else $error("rsv");
  cover property (reg_rd && reg_addr == 12'h204 && upstream_port);
  cover property (reg_rd && reg_addr == 12'h208);
  cover property (reg_wr ##[1:4] reg_rd);
endmodule
bind vc_port_capability_regs vc_cap_asserts u_chk (.core_clk(core_clk), .reset(reset),
  .upstream_port(upstream_port), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        upstream_port = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  int          miscompares = 0;
  int          total_checks = 0;
  vc_port_capability_regs u_dut (.core_clk(core_clk), .reset(reset), .upstream_port(upstream_port),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  initial forever #2 core_clk = ~core_clk;
  // ==========================================
  // Bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e);
    @(negedge core_clk) chk(reg_rdata, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= 32'hffff_ffff;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk) chk(reg_rdata, 32'h0);
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk) chk(reg_rdata, 32'h0);
    for (int up = 0; up < 2; up++) begin
      @(posedge core_clk) upstream_port <= up[0];
      wr(12'h204);
      rd(12'h204, up[0] ? 32'h0000_0800 : 32'h0);
      wr(12'h208);
      rd(12'h208, 32'h0);
      rd(12'h204, up[0] ? 32'h0000_0800 : 32'h0);
      rd(12'h20c, 32'h0);
    end
    wrap_up;
  end
  initial begin
    #2000 miscompares++;
    wrap_up;
  end
endmodule
